// ---- inc/ovfc_consts.svh ----
`ifndef OVFC_CONSTS_SVH
`define OVFC_CONSTS_SVH

// command codes
`define OVFC_CMD_OV_RESP     8'h41
`define OVFC_CMD_UV_LIMIT    8'h44
`define OVFC_CMD_STATUS      8'h7a
`define OVFC_CMD_CLEAR       8'h03

// reset values
`define OVFC_OV_RESP_RST     8'h80
`define OVFC_UV_LIMIT_RST    16'h0000

// response register fields
`define OVFC_BEHAV_HI        7
`define OVFC_BEHAV_LO        6
`define OVFC_RETRY_HI        5
`define OVFC_RETRY_LO        3
`define OVFC_BEHAV_RETRY     2'h2
`define OVFC_RETRY_NONE      3'h0
`define OVFC_RETRY_FOREVER   3'h7

// status register fields
`define OVFC_STAT_OV         0
`define OVFC_STAT_UV         1

// default undervoltage limit is strap * 17 / 20 (0.85)
`define OVFC_UV_NUM          21'h000011
`define OVFC_UV_DEN          21'h000014

// timing
`define OVFC_CLK_KHZ         50000
`define OVFC_RETRY_MS        70
`define OVFC_TMR_W           22

`endif

// ---- inc/ovfc_pkg.sv ----
package ovfc_pkg;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_RUN,
    ST_HOLD,
    ST_RETRY
  } ovfc_state_e;

  typedef logic [7:0]  ovfc_cmd_t;
  typedef logic [15:0] ovfc_word_t;

endpackage : ovfc_pkg

// ---- inc/ovfc_timer_if.sv ----
`timescale 1ns/1ns
interface ovfc_timer_if;
  logic start;
  logic cancel;
  logic expired;

  modport ctl (output start, output cancel, input expired);
  modport tmr (input start, input cancel, output expired);
endinterface : ovfc_timer_if

// ---- core/ovfc_retry_timer.sv ----
`timescale 1ns/1ns
`include "ovfc_consts.svh"
module ovfc_retry_timer #(
  parameter logic [`OVFC_TMR_W-1:0] CYCLES = `OVFC_TMR_W'(1)
) (
  input  wire logic  clk,
  input  wire logic  rstn,
  ovfc_timer_if.tmr  tif
);
  logic [`OVFC_TMR_W-1:0] count;
  logic                   running;
  logic                   done;

  assign done = running && (count == '0);

  always_ff @(posedge clk) begin
    if (!rstn || tif.cancel) begin
      running     <= 1'b0;
      count       <= '0;
      tif.expired <= 1'b0;
    end else if (tif.start) begin
      running     <= 1'b1;
      count       <= CYCLES - `OVFC_TMR_W'(1);
      tif.expired <= 1'b0;
    end else begin
      running     <= running && !done;
      count       <= done ? count : count - `OVFC_TMR_W'(running);
      tif.expired <= done;
    end
  end
endmodule : ovfc_retry_timer

// ---- core/ovfc_top.sv ----
`timescale 1ns/1ns
`include "ovfc_consts.svh"
// Function
// - response register resets to 80h: shut down at once, no restart.
// - behaviour code 10 disables output and retries only for retry code 111.
// - an overvoltage fault drives the active-low alert output low.
// - faults set sticky status bits cleared only by the clear-faults command.
// - retry code 000 keeps output off until it is restarted.
// - with behaviour code 10, retry code 111 restarts after every fault, endlessly until commanded off.
// - restart interval fixed at 70 ms; low three bits do nothing.
// - undervoltage limit is unsigned 16 bits, volts = value times 2^-13.
// - undervoltage limit defaults to 0.85 times the strapped setpoint.
// - undervoltage detection masked while ramping, before power-good, or off.
module ovfc_top
  import ovfc_pkg::*;
#(
  parameter int unsigned RETRY_CYCLES = `OVFC_RETRY_MS * `OVFC_CLK_KHZ
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire ovfc_cmd_t   cmd_code,
  input  wire ovfc_word_t  cmd_wdata,
  input  wire logic        enable_req,
  input  wire logic        ov_detect,
  input  wire ovfc_word_t  vout_meas,
  input  wire ovfc_word_t  vout_strap,
  input  wire logic        ramping,
  input  wire logic        power_good,
  output ovfc_word_t       cmd_rdata,
  output logic             cmd_rvalid,
  output logic             out_enable,
  output logic             alert_out_n,
  output logic             ov_fault,
  output logic             uv_fault
);

  function automatic logic cmd_hit(input ovfc_cmd_t code,
                                   input ovfc_cmd_t target);
    cmd_hit = cmd_valid && (code == target);
  endfunction : cmd_hit

  logic [7:0]  ov_resp;
  ovfc_word_t  uv_limit;
  logic        strap_pending;
  ovfc_state_e state;
  ovfc_state_e next_state;
  logic        prev_ov;

  ovfc_timer_if tif ();

  ovfc_retry_timer #(
    .CYCLES (`OVFC_TMR_W'(RETRY_CYCLES))
  ) u_timer (
    .clk  (clk),
    .rstn (rstn),
    .tif  (tif)
  );

  // command decode
  wire wr_resp  = cmd_hit(cmd_code, `OVFC_CMD_OV_RESP) && cmd_write;
  wire wr_limit = cmd_hit(cmd_code, `OVFC_CMD_UV_LIMIT) && cmd_write;
  wire do_clear = cmd_hit(cmd_code, `OVFC_CMD_CLEAR) && cmd_write;
  wire rd_any   = cmd_valid && !cmd_write;

  // response fields
  wire [1:0] behav = ov_resp[`OVFC_BEHAV_HI:`OVFC_BEHAV_LO];
  wire [2:0] retry = ov_resp[`OVFC_RETRY_HI:`OVFC_RETRY_LO];
  wire retry_on    = (behav == `OVFC_BEHAV_RETRY) &&
                     (retry == `OVFC_RETRY_FOREVER);

  // default limit from the strapped setpoint
  wire [20:0] strap_prod   = {5'h00, vout_strap} * `OVFC_UV_NUM;
  wire [20:0] strap_scaled = strap_prod / `OVFC_UV_DEN;

  // fault detection
  wire ov_event = (state == ST_RUN) && ov_detect && !prev_ov;
  wire uv_mask  = ramping || !power_good || !out_enable;
  wire uv_event = !uv_mask && (vout_meas < uv_limit);

  // sticky flags, one slice per status bit
  wire [1:0] flag_event;
  wire [1:0] flag_now;
  wire [1:0] next_flag;
  assign flag_event[`OVFC_STAT_OV] = ov_event;
  assign flag_event[`OVFC_STAT_UV] = uv_event;
  assign flag_now[`OVFC_STAT_OV]   = ov_fault;
  assign flag_now[`OVFC_STAT_UV]   = uv_fault;

  // a new event wins over a clear in the same cycle
  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_sticky
    assign next_flag[gi] = flag_event[gi] ||
                           (flag_now[gi] && !do_clear);
  end

  // read select
  wire rd_resp  = cmd_hit(cmd_code, `OVFC_CMD_OV_RESP);
  wire rd_limit = cmd_hit(cmd_code, `OVFC_CMD_UV_LIMIT);
  wire rd_stat  = cmd_hit(cmd_code, `OVFC_CMD_STATUS);
  wire ovfc_word_t status_word = {14'h0000, flag_now};
  wire ovfc_word_t rd_mux = rd_resp  ? {8'h00, ov_resp} :
                            rd_limit ? uv_limit :
                            rd_stat  ? status_word : 16'h0000;

  // next state
  // every response but disable-and-retry-forever parks in hold
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (enable_req) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!enable_req) begin
          next_state = ST_OFF;
        end else if (ov_event) begin
          next_state = retry_on ? ST_RETRY : ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!enable_req) begin
          next_state = ST_OFF;
        end
      end
      ST_RETRY: begin
        if (!enable_req) begin
          next_state = ST_OFF;
        end else if (tif.expired) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  // retry interval timer control
  // a cancel also drops a pending expiry so no stale restart follows
  assign tif.start  = (state == ST_RUN) && (next_state == ST_RETRY);
  assign tif.cancel = (state == ST_RETRY) && !enable_req;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state      <= ST_OFF;
      out_enable <= 1'b0;
    end else begin
      state      <= next_state;
      out_enable <= (next_state == ST_RUN);
    end
  end

  // previous comparator level: a held level must not trip twice
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prev_ov <= 1'b0;
    end else begin
      prev_ov <= ov_detect;
    end
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ov_resp <= `OVFC_OV_RESP_RST;
    end else if (wr_resp) begin
      ov_resp <= cmd_wdata[7:0];
    end
  end

  // the strapped default lands one edge after reset; a write there wins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      strap_pending <= 1'b1;
    end else begin
      strap_pending <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      uv_limit <= `OVFC_UV_LIMIT_RST;
    end else if (wr_limit) begin
      uv_limit <= cmd_wdata;
    end else if (strap_pending) begin
      uv_limit <= strap_scaled[15:0];
    end
  end

  // sticky status flags
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ov_fault <= 1'b0;
      uv_fault <= 1'b0;
    end else begin
      ov_fault <= next_flag[`OVFC_STAT_OV];
      uv_fault <= next_flag[`OVFC_STAT_UV];
    end
  end

  // alert follows the flags as they will stand after this edge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      alert_out_n <= 1'b1;
    end else begin
      alert_out_n <= !(|next_flag);
    end
  end

  // read data is zero whenever no read answer stands
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmd_rdata  <= 16'h0000;
      cmd_rvalid <= 1'b0;
    end else begin
      cmd_rdata  <= rd_any ? rd_mux : 16'h0000;
      cmd_rvalid <= rd_any;
    end
  end

endmodule : ovfc_top

// ---- verification/ovfc_chk.sv ----
`timescale 1ns/1ns
module ovfc_chk
  import ovfc_pkg::*;
#(parameter int unsigned RETRY_CYCLES = 20) (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       cmd_valid,
  input wire logic       cmd_write,
  input wire ovfc_cmd_t  cmd_code,
  input wire logic       enable_req,
  input wire logic       ov_detect,
  input wire logic       ramping,
  input wire logic       power_good,
  input wire ovfc_word_t cmd_rdata,
  input wire logic       cmd_rvalid,
  input wire logic       out_enable,
  input wire logic       alert_out_n,
  input wire logic       ov_fault,
  input wire logic       uv_fault
);
  wire logic clr = cmd_valid && cmd_write && cmd_code == 8'h03;
  wire logic rd = cmd_valid && !cmd_write;
  int unsigned off_n;
  // off cycles while still requested on
  always_ff @(posedge clk)
    off_n <= (!rstn || !enable_req || out_enable) ? 0 : off_n + 1;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_ov_trip: assert property (
    out_enable && ov_detect && !$past(ov_detect) |=>
    ov_fault && !alert_out_n && !out_enable) else $error("no trip");
  a_alert_flags: assert property (
    alert_out_n == !(ov_fault || uv_fault)) else $error("alert");
  a_flag_sticky: assert property (
    ov_fault && !clr |=> ov_fault) else $error("flag lost");
  a_flag_clear: assert property (
    clr && !out_enable |=> !ov_fault && !uv_fault) else $error("no clear");
  a_uv_mask: assert property (
    (ramping || !power_good || !out_enable) && !uv_fault |=> !uv_fault)
    else $error("uv unmasked");
  a_read_pulse: assert property (
    cmd_rvalid == $past(rd)) else $error("read pulse");
  a_rdata_idle: assert property (
    !cmd_rvalid |-> cmd_rdata == 16'h0000) else $error("rdata");
  a_retry_gap: assert property (
    $rose(out_enable) && off_n > 1 |->
    off_n >= RETRY_CYCLES && off_n <= RETRY_CYCLES + 2)
    else $error("restart gap");
endmodule : ovfc_chk
bind ovfc_top ovfc_chk #(.RETRY_CYCLES(RETRY_CYCLES)) i_chk (.clk, .rstn,
  .cmd_valid, .cmd_write, .cmd_code, .enable_req, .ov_detect, .ramping,
  .power_good, .cmd_rdata, .cmd_rvalid, .out_enable, .alert_out_n,
  .ov_fault, .uv_fault);

// ---- verification/ovfc_host.sv ----
`timescale 1ns/1ns
module ovfc_host
  import ovfc_pkg::*;
(
  input  wire logic       clk,
  input  wire ovfc_word_t cmd_rdata,
  input  wire logic       cmd_rvalid,
  output ovfc_word_t      cmd_wdata,
  output ovfc_cmd_t       cmd_code,
  output logic            cmd_valid,
  output logic            cmd_write
);
  initial {cmd_valid, cmd_write, cmd_code, cmd_wdata} = '0;
  task automatic xfer(input logic w, input ovfc_cmd_t c,
                      input ovfc_word_t d, output ovfc_word_t q);
    @(negedge clk);
    {cmd_valid, cmd_write, cmd_code, cmd_wdata} = {1'b1, w, c, d};
    @(negedge clk);
    q = cmd_rvalid ? cmd_rdata : 16'hdead;
    // released qualifiers show the inverse of the last value
    {cmd_valid, cmd_write, cmd_code, cmd_wdata} = {1'b0, ~w, ~c, ~d};
  endtask : xfer
endmodule : ovfc_host

// ---- verification/ovfc_bench.sv ----
`timescale 1ns/1ns
module ovfc_bench
  import ovfc_pkg::*;
;
  localparam int RC = 20;
  logic        clk = 1'b0, rstn = 1'b0, enable_req = 1'b0, ov_detect = 1'b0;
  logic        ramping = 1'b0, power_good = 1'b1, cmd_valid, cmd_write;
  logic        cmd_rvalid, out_enable, alert_out_n, ov_fault, uv_fault;
  ovfc_cmd_t   cmd_code;
  ovfc_word_t  cmd_wdata, cmd_rdata, q, lim, vout_meas = 16'hffff, vout_strap;
  logic [31:0] seed = 32'h429ca010;
  logic [7:0]  codes [7] = '{8'hb8, 8'hb8, 8'h80, 8'h00, 8'hf8, 8'hc0, 8'h88};
  int          fail_count = 0, n_checks = 0, cyc = 0, n_wait = 0;
  always #10 clk = ~clk;
  ovfc_top #(.RETRY_CYCLES(RC)) i_dut (.clk, .rstn, .cmd_valid, .cmd_write,
    .cmd_code, .cmd_wdata, .enable_req, .ov_detect, .vout_meas, .vout_strap,
    .ramping, .power_good, .cmd_rdata, .cmd_rvalid, .out_enable,
    .alert_out_n, .ov_fault, .uv_fault);
  ovfc_host i_host (.clk, .cmd_rdata, .cmd_rvalid, .cmd_wdata, .cmd_code,
    .cmd_valid, .cmd_write);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic ovfc_word_t uv_def(input ovfc_word_t s);
    return 16'((32'(s) * 17) / 20);
  endfunction : uv_def
  function automatic logic [15:0] st();
    return 16'({uv_fault, ov_fault, alert_out_n, out_enable});
  endfunction : st
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("Error %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  task automatic rd(input ovfc_cmd_t c, input ovfc_word_t e);
    i_host.xfer(1'b0, c, 16'h0000, q);
    chk(q, e);
  endtask : rd
  task automatic wait_on(input int lim_n, output int n);
    for (n = 0; n < lim_n && !out_enable; n++) @(negedge clk);
  endtask : wait_on
  task automatic run_up;
    int n;
    enable_req = 1'b0;
    repeat (2) @(negedge clk);
    enable_req = 1'b1;
    wait_on(10, n);
  endtask : run_up
  task automatic trip(input logic [7:0] code);
    int n;
    logic rt;
    rt = code[7:3] == 5'b10111;
    seed = lfsr(seed);
    i_host.xfer(1'b1, 8'h41, {8'h00, code[7:3], seed[2:0]}, q);
    ov_detect = 1'b1;
    repeat (2) @(negedge clk);
    ov_detect = 1'b0;
    chk(st(), 16'h4);
    wait_on(RC + 8, n);
    chk(16'(n >= RC && n <= RC + 3), 16'(rt));
    i_host.xfer(1'b1, 8'h7a, 16'h0000, q);
    rd(8'h7a, 16'h0001);
    i_host.xfer(1'b1, 8'h03, 16'h0000, q);
    chk(st(), {14'h0, 1'b1, rt});
    if (!rt) run_up();
    $display("trip %h done", code);
  endtask : trip
  task automatic uv(input ovfc_word_t m, input logic r, input logic p,
                    input logic [15:0] e);
    {vout_meas, ramping, power_good} = {m, r, p};
    repeat (3) @(negedge clk);
    chk(st(), e);
  endtask : uv
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    seed = lfsr(seed);
    vout_strap = seed[15:0];
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    rd(8'h41, 16'h0080);
    rd(8'h44, uv_def(vout_strap));
    $display("reset test done");
    run_up();
    foreach (codes[i]) trip(codes[i]);
    i_host.xfer(1'b1, 8'h41, 16'h00b8, q);
    ov_detect = 1'b1;
    repeat (3) @(negedge clk);
    {enable_req, ov_detect} = 2'b00;
    wait_on(RC + 8, n_wait);
    chk(st(), 16'h4);
    i_host.xfer(1'b1, 8'h03, 16'h0000, q);
    run_up();
    $display("cancel test done");
    lim = seed[31:16] | 16'h0001;
    i_host.xfer(1'b1, 8'h44, lim, q);
    rd(8'h44, lim);
    uv(lim, 1'b0, 1'b1, 16'h3);
    uv(lim - 16'h1, 1'b1, 1'b1, 16'h3);
    uv(lim - 16'h1, 1'b0, 1'b0, 16'h3);
    uv(lim - 16'h1, 1'b0, 1'b1, 16'h9);
    $display("uv test done");
    complete_run();
  end
endmodule : ovfc_bench
